// ==== logic/core_cfg.svh ====
// Constants for the instruction decode and execute core
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH

`define AXI_AW         8
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`define REG_OPCODE     8'h00
`define REG_STATUS     8'h04
`define REG_WORK       8'h08
`define REG_BANK       8'h0C
`define REG_PC         8'h10
`define REG_PCLATCH    8'h14
`define REG_FILE_ADDR  8'h18
`define REG_FILE_DATA  8'h1C
`define REG_PRODUCT    8'h20

`define ST_C           0
`define ST_DC          1
`define ST_Z           2
`define ST_OV          3
`define ST_PD          4
`define ST_TO          5
`define ST_GLOBAL_INTERRUPT_DISABLE      6
`define ST_BUSY        7
`define ST_CYC_LO      8
`define ST_CYC_HI      9

`define RST_PC         16'h0000
`define RST_TO         1'h1
`define RST_PD         1'h1
`define RST_GLOBAL_INTERRUPT_DISABLE     1'h1

`define PCL_FILE_ADDR  8'h02
`define FILE_DEPTH     256
`define STACK_DEPTH    4

`define OP_XOR_ACCUM_FILE       7'h06
`define OP_ADD_ACCUM_FILE       7'h07
`define OP_ADD_ACCUM_FILE_CARRY      7'h08
`define OP_CLRF        7'h14
`define OP_SETF        7'h15
`define OP_TEST_FILE_SKIP_ZERO      8'h33
`define OP_BTG         5'h07
`define OP_BSF         5'h10
`define OP_BCF         5'h11
`define OP_BIT_TEST_SKIP_SET       5'h12
`define OP_BIT_TEST_SKIP_CLEAR       5'h13
`define OP_TABLE_READ_OP      6'h2A
`define OP_LOAD_LITERAL_ACCUM       8'hB0
`define OP_ADD_LITERAL_ACCUM       8'hB1
`define OP_SUB_ACCUM_FROM_LITERAL       8'hB2
`define OP_OR_LITERAL_ACCUM       8'hB3
`define OP_XOR_LITERAL_ACCUM       8'hB4
`define OP_AND_LITERAL_ACCUM       8'hB5
`define OP_RETURN_WITH_LITERAL       8'hB6
`define OP_LONG_SUBROUTINE_CALL       8'hB7
`define OP_LOAD_BANK_LOW_NIBBLE       8'hB8
`define OP_LOAD_BANK_HIGH_NIBBLE       7'h5D
`define OP_MULTIPLY_LITERAL_ACCUM       8'hBC
`define OP_UNCONDITIONAL_BRANCH        3'h6
`define OP_CALL        3'h7
`define OP_RETURN      16'h0002
`define OP_SLEEP       16'h0003
`define OP_WATCHDOG_CLEAR      16'h0004
`define OP_INTERRUPT_RETURN      16'h0005

`endif

// ==== logic/core_pkg.sv ====
// Types shared by the instruction decode and execute core
package core_pkg;

	typedef enum logic [1:0]
	{
		Q1 = 2'b00,
		Q2 = 2'b01,
		Q3 = 2'b10,
		Q4 = 2'b11
	} phase_t;

	typedef struct packed
	{
		logic [7:0] res;
		logic       c;
		logic       dc;
		logic       ov;
	} alu_t;

	typedef struct packed
	{
		logic             busy;
		phase_t           q;
		logic [1:0]       cyc;
		logic [1:0]       ncyc;
		logic [1:0]       last_cyc;
		logic [15:0]      ir;
		logic [7:0]       opnd;
		logic [7:0]       work;
		logic [7:0]       bank;
		logic [7:0]       pclatch;
		logic [15:0]      pc;
		logic [3:0][15:0] stk;
		logic [1:0]       sp;
		logic             c;
		logic             dc;
		logic             z;
		logic             ov;
		logic             to;
		logic             pd;
		logic             global_interrupt_disable;
		logic [15:0]      prod;
		logic             wdt_clr;
		logic             sleep;
		logic             aw_got;
		logic [7:0]       awaddr;
		logic             w_got;
		logic [15:0]      wdata;
		logic [1:0]       wstrb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
		logic [7:0]       faddr;
	} state_t;

endpackage

// ==== logic/insn_core.sv ====
// Instruction decode and execute core with an AXI4-Lite register port
// Functional notes
// - XOR accumulator with file register, result to d destination, zero flag only.
// - Bit tests skip on clear or set; zero test skips when file is zero.
// - Conditional skips take one cycle, or two when the skip happens.
// - A taken skip replaces the prefetched instruction with a no-operation.
// - Add literal to accumulator, updating overflow, carry, digit carry, zero.
// - AND, OR, XOR literal into accumulator, zero flag only.
// - Literal minus accumulator into accumulator, all four arithmetic flags.
// - Multiply literal by accumulator; load literal; single cycle, no flags.
// - Load four-bit literal into bank low nibble, high nibble kept.
// - Load literal bits 7..4 into bank high nibble, low nibble kept.
// - Calls, branches, returns take two cycles; table read to PC low three.
// - Long call saves return address, loads PC from high latch and literal.
// - Interrupt return clears global interrupt disable; two cycles.
// - Return with literal loads accumulator; plain return keeps it; no flags.
// - Watchdog clear and sleep update timeout and powerdown flags.
// - Add accumulator to file register, d selects destination, four flags.
// - Add accumulator, carry and file byte, d destination, four flags.
// - Single-target bit 1 writes file only; 0 writes file and accumulator.
// - Four phases per cycle: decode, operand read, process, write.
`include "core_cfg.svh"

module insn_core
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [`AXI_AW-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [`AXI_AW-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   wdt_clear,
	output logic                   sleep_enter
);
	import core_pkg::*;

	core_pkg::state_t s_r;
	core_pkg::state_t s_nxt;

	logic [7:0] file_mem [0:`FILE_DEPTH-1];
	logic       fm_we;
	logic [7:0] fm_wa;
	logic [7:0] fm_wd;

	// Eight-bit add with carry in; subtraction passes the inverted operand
	function automatic alu_t add8(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [8:0] sum;
		logic [4:0] lo;
		alu_t       r;
		sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		r.res = sum[7:0];
		r.c = sum[8];
		r.dc = lo[4];
		r.ov = (a[7] == b[7]) && (sum[7] != a[7]);
		return r;
	endfunction

	always_comb
	begin
		logic [7:0]  f;
		logic [7:0]  op;
		logic [2:0]  bit_n;
		logic [7:0]  k;
		logic [7:0]  mask;
		logic [1:0]  nc;
		logic [15:0] pcn;
		alu_t        a;
		logic        arith;
		logic        logic_op;
		logic        dest_f;
		logic        dest_w;
		logic [7:0]  res;
		f = s_r.ir[7:0];
		op = s_r.ir[15:8];
		bit_n = s_r.ir[10:8];
		k = s_r.ir[7:0];
		mask = 8'h01 << bit_n;
		nc = 2'h1;
		pcn = s_r.pc + 16'h0001;
		a = '0;
		arith = 1'b0;
		logic_op = 1'b0;
		dest_f = 1'b0;
		dest_w = 1'b0;
		res = 8'h00;
		s_nxt = s_r;
		s_nxt.wdt_clr = 1'b0;
		s_nxt.sleep = 1'b0;
		fm_we = 1'b0;
		fm_wa = f;
		fm_wd = 8'h00;

		if (s_r.busy)
		begin
			s_nxt.q = phase_t'(s_r.q + 2'h1);
			unique case (s_r.q)
				Q1: ;
				Q2: s_nxt.opnd = file_mem[f];
				Q3: ;
				Q4:
				begin
					if (s_r.cyc == 2'h0)
					begin
						// Commit happens once, in the write phase of cycle one
						if (op[7:1] == `OP_XOR_ACCUM_FILE)
						begin
							res = s_r.work ^ s_r.opnd;
							logic_op = 1'b1;
							dest_f = op[0];
							dest_w = !op[0];
						end
						else if (op[7:1] == `OP_ADD_ACCUM_FILE || op[7:1] == `OP_ADD_ACCUM_FILE_CARRY)
						begin
							a = add8(s_r.work, s_r.opnd,
								op[7:1] == `OP_ADD_ACCUM_FILE_CARRY && s_r.c);
							res = a.res;
							arith = 1'b1;
							dest_f = op[0];
							dest_w = !op[0];
						end
						else if (op[7:1] == `OP_CLRF || op[7:1] == `OP_SETF)
						begin
							res = {8{op[7:1] == `OP_SETF}};
							dest_f = 1'b1;
							dest_w = !op[0];
						end
						else if (op == `OP_TEST_FILE_SKIP_ZERO)
						begin
							if (s_r.opnd == 8'h00)
							begin
								nc = 2'h2;
								pcn = s_r.pc + 16'h0002;
							end
						end
						else if (op[7:3] == `OP_BTG || op[7:3] == `OP_BSF
							|| op[7:3] == `OP_BCF)
						begin
							dest_f = 1'b1;
							if (op[7:3] == `OP_BTG)
								res = s_r.opnd ^ mask;
							else if (op[7:3] == `OP_BSF)
								res = s_r.opnd | mask;
							else
								res = s_r.opnd & ~mask;
						end
						else if (op[7:3] == `OP_BIT_TEST_SKIP_SET || op[7:3] == `OP_BIT_TEST_SKIP_CLEAR)
						begin
							if (((s_r.opnd & mask) != 8'h00)
								== (op[7:3] == `OP_BIT_TEST_SKIP_SET))
							begin
								nc = 2'h2;
								pcn = s_r.pc + 16'h0002;
							end
						end
						else if (op[7:2] == `OP_TABLE_READ_OP)
							nc = (f == `PCL_FILE_ADDR) ? 2'h3 : 2'h2;
						else if (op == `OP_LOAD_LITERAL_ACCUM)
						begin
							res = k;
							dest_w = 1'b1;
						end
						else if (op == `OP_ADD_LITERAL_ACCUM || op == `OP_SUB_ACCUM_FROM_LITERAL)
						begin
							if (op == `OP_ADD_LITERAL_ACCUM)
								a = add8(s_r.work, k, 1'b0);
							else
								a = add8(k, ~s_r.work, 1'b1);
							res = a.res;
							arith = 1'b1;
							dest_w = 1'b1;
						end
						else if (op == `OP_OR_LITERAL_ACCUM || op == `OP_XOR_LITERAL_ACCUM
							|| op == `OP_AND_LITERAL_ACCUM)
						begin
							if (op == `OP_OR_LITERAL_ACCUM)
								res = s_r.work | k;
							else if (op == `OP_XOR_LITERAL_ACCUM)
								res = s_r.work ^ k;
							else
								res = s_r.work & k;
							logic_op = 1'b1;
							dest_w = 1'b1;
						end
						else if (op == `OP_MULTIPLY_LITERAL_ACCUM)
							s_nxt.prod = {8'h00, s_r.work} * {8'h00, k};
						else if (op == `OP_LOAD_BANK_LOW_NIBBLE)
							s_nxt.bank = {s_r.bank[7:4], k[3:0]};
						else if (op[7:1] == `OP_LOAD_BANK_HIGH_NIBBLE)
							s_nxt.bank = {k[7:4], s_r.bank[3:0]};
						else if (op == `OP_LONG_SUBROUTINE_CALL || op[7:5] == `OP_CALL
							|| op[7:5] == `OP_UNCONDITIONAL_BRANCH)
						begin
							nc = 2'h2;
							if (op[7:5] != `OP_UNCONDITIONAL_BRANCH)
							begin
								s_nxt.stk[s_r.sp] = s_r.pc + 16'h0001;
								s_nxt.sp = s_r.sp + 2'h1;
							end
							if (op == `OP_LONG_SUBROUTINE_CALL)
								pcn = {s_r.pclatch, k};
							else
								pcn = {s_r.pc[15:13], s_r.ir[12:0]};
						end
						else if (op == `OP_RETURN_WITH_LITERAL || s_r.ir == `OP_RETURN
							|| s_r.ir == `OP_INTERRUPT_RETURN)
						begin
							nc = 2'h2;
							s_nxt.sp = s_r.sp - 2'h1;
							pcn = s_r.stk[s_r.sp - 2'h1];
							if (op == `OP_RETURN_WITH_LITERAL)
								s_nxt.work = k;
							if (s_r.ir == `OP_INTERRUPT_RETURN)
								s_nxt.global_interrupt_disable = 1'b0;
						end
						else if (s_r.ir == `OP_WATCHDOG_CLEAR)
						begin
							s_nxt.to = 1'b1;
							s_nxt.pd = 1'b1;
							s_nxt.wdt_clr = 1'b1;
						end
						else if (s_r.ir == `OP_SLEEP)
						begin
							s_nxt.to = 1'b1;
							s_nxt.pd = 1'b0;
							s_nxt.sleep = 1'b1;
						end

						if (arith)
						begin
							s_nxt.c = a.c;
							s_nxt.dc = a.dc;
							s_nxt.ov = a.ov;
						end
						if (arith || logic_op)
							s_nxt.z = (res == 8'h00);
						if (dest_w)
							s_nxt.work = res;
						if (dest_f)
						begin
							fm_we = 1'b1;
							fm_wd = res;
						end
						s_nxt.pc = pcn;
						s_nxt.ncyc = nc;
						if (nc == 2'h1)
						begin
							s_nxt.busy = 1'b0;
							s_nxt.last_cyc = 2'h1;
						end
						s_nxt.cyc = 2'h1;
					end
					else
					begin
						// Later cycles are forced no-operations
						s_nxt.cyc = s_r.cyc + 2'h1;
						if (s_r.cyc + 2'h1 == s_r.ncyc)
						begin
							s_nxt.busy = 1'b0;
							s_nxt.last_cyc = s_r.ncyc;
						end
					end
				end
			endcase
		end

		// Write address and data are caught in either order
		if (awvalid && !s_r.aw_got)
		begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = awaddr;
		end
		if (wvalid && !s_r.w_got)
		begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = wdata[15:0];
			s_nxt.wstrb = wstrb[1:0];
		end
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
		begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = `RESP_OKAY;
			// Writes during execution are dropped to keep state coherent
			if (!s_r.busy && s_r.wstrb[0])
			begin
				unique case (s_r.awaddr)
					`REG_OPCODE:
						if (s_r.wstrb[1])
						begin
							s_nxt.ir = s_r.wdata;
							s_nxt.busy = 1'b1;
							s_nxt.q = Q1;
							s_nxt.cyc = 2'h0;
						end
					`REG_STATUS:
					begin
						s_nxt.c = s_r.wdata[`ST_C];
						s_nxt.dc = s_r.wdata[`ST_DC];
						s_nxt.z = s_r.wdata[`ST_Z];
						s_nxt.ov = s_r.wdata[`ST_OV];
						s_nxt.pd = s_r.wdata[`ST_PD];
						s_nxt.to = s_r.wdata[`ST_TO];
						s_nxt.global_interrupt_disable = s_r.wdata[`ST_GLOBAL_INTERRUPT_DISABLE];
					end
					`REG_WORK: s_nxt.work = s_r.wdata[7:0];
					`REG_BANK: s_nxt.bank = s_r.wdata[7:0];
					`REG_PC:
						if (s_r.wstrb[1])
							s_nxt.pc = s_r.wdata;
					`REG_PCLATCH: s_nxt.pclatch = s_r.wdata[7:0];
					`REG_FILE_ADDR: s_nxt.faddr = s_r.wdata[7:0];
					`REG_FILE_DATA:
					begin
						fm_we = 1'b1;
						fm_wa = s_r.faddr;
						fm_wd = s_r.wdata[7:0];
					end
					`REG_PRODUCT: ;
					default: s_nxt.bresp = `RESP_SLVERR;
				endcase
			end
		end
		if (s_r.bvalid && bready)
			s_nxt.bvalid = 1'b0;

		if (arvalid && !s_r.rvalid)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = `RESP_OKAY;
			s_nxt.rdata = 32'h0000_0000;
			unique case (araddr)
				`REG_OPCODE: s_nxt.rdata[15:0] = s_r.ir;
				`REG_STATUS:
				begin
					s_nxt.rdata[`ST_C] = s_r.c;
					s_nxt.rdata[`ST_DC] = s_r.dc;
					s_nxt.rdata[`ST_Z] = s_r.z;
					s_nxt.rdata[`ST_OV] = s_r.ov;
					s_nxt.rdata[`ST_PD] = s_r.pd;
					s_nxt.rdata[`ST_TO] = s_r.to;
					s_nxt.rdata[`ST_GLOBAL_INTERRUPT_DISABLE] = s_r.global_interrupt_disable;
					s_nxt.rdata[`ST_BUSY] = s_r.busy;
					s_nxt.rdata[`ST_CYC_HI:`ST_CYC_LO] = s_r.last_cyc;
				end
				`REG_WORK: s_nxt.rdata[7:0] = s_r.work;
				`REG_BANK: s_nxt.rdata[7:0] = s_r.bank;
				`REG_PC: s_nxt.rdata[15:0] = s_r.pc;
				`REG_PCLATCH: s_nxt.rdata[7:0] = s_r.pclatch;
				`REG_FILE_ADDR: s_nxt.rdata[7:0] = s_r.faddr;
				`REG_FILE_DATA: s_nxt.rdata[7:0] = file_mem[s_r.faddr];
				`REG_PRODUCT: s_nxt.rdata[15:0] = s_r.prod;
				default: s_nxt.rresp = `RESP_SLVERR;
			endcase
		end
		if (s_r.rvalid && rready)
			s_nxt.rvalid = 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_r <= '0;
			s_r.pc <= `RST_PC;
			s_r.to <= `RST_TO;
			s_r.pd <= `RST_PD;
			s_r.global_interrupt_disable <= `RST_GLOBAL_INTERRUPT_DISABLE;
		end
		else
			s_r <= s_nxt;
	end

	// File memory is not reset; software preloads what it needs
	always_ff @(posedge aclk)
	begin
		if (fm_we)
			file_mem[fm_wa] <= fm_wd;
	end

	assign awready = !s_r.aw_got;
	assign wready = !s_r.w_got;
	assign bvalid = s_r.bvalid;
	assign bresp = s_r.bresp;
	assign arready = !s_r.rvalid;
	assign rvalid = s_r.rvalid;
	assign rdata = s_r.rdata;
	assign rresp = s_r.rresp;
	assign wdt_clear = s_r.wdt_clr;
	assign sleep_enter = s_r.sleep;

endmodule

// ==== testbench/insn_core_properties.sv ====
// Bus handshake and pulse properties of the instruction core
module insn_core_chk
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        awready,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic        wdt_clear,
	input wire logic        sleep_enter
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("bresp not held");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("rdata not held");
	ar_gate_a: assert property (arready == !rvalid)
		else $error("arready wrong");
	r_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	// Next address may be caught while a response waits
	w_answer_a: assert property (!awready && !wready && !bvalid |=> bvalid)
		else $error("write answer late");
	wdt_pulse_a: assert property (wdt_clear |=> !wdt_clear [*3])
		else $error("watchdog pulse too long");
	sleep_pulse_a: assert property (sleep_enter |=> !sleep_enter [*3])
		else $error("sleep pulse too long");
	pulse_excl_a: assert property (!(wdt_clear && sleep_enter))
		else $error("both pulses at once");
	cover property (wdt_clear);
	cover property (sleep_enter);
	cover property (bvalid && bresp == 2'h2);
endmodule

// ==== testbench/insn_core_tb_top.sv ====
// Self-checking bench for the instruction core
`include "core_cfg.svh"
`define CHK(n, x, y) \
	begin \
		check_count++; \
		if ((y) !== (x)) \
		begin \
			mismatches++; \
			$display("[FAIL] %s exp %0h got %0h", n, x, y); \
		end \
	end

module insn_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import core_pkg::*;
	logic        aclk = 0, aresetn = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, s, v;
	logic [3:0]  wstrb = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0;
	logic        arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        wdt_clear, sleep_enter;
	logic [1:0]  bresp, rresp, r;
	int          mismatches = 0, check_count = 0, wd_n = 0, sl_n = 0;

	insn_core dut_u
	(
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .wdt_clear(wdt_clear),
		.sleep_enter(sleep_enter)
	);

	always #4 aclk = ~aclk;

	always @(posedge aclk)
	begin
		if (wdt_clear === 1'b1)
			wd_n++;
		if (sleep_enter === 1'b1)
			sl_n++;
	end

	function automatic logic [11:0] arith(logic [7:0] a, logic [7:0] b,
		logic ci);
		logic [8:0] t;
		logic [4:0] h;
		t = a + b + ci;
		h = a[3:0] + b[3:0] + ci;
		return {(a[7] == b[7]) && (t[7] != a[7]), t[7:0] == 8'h00,
			h[4], t[8], t[7:0]};
	endfunction

	// Ready sampled at the falling edge: registered, so it equals
	// what the next rising edge sees, with no race against the DUT
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] q);
		logic ta, tw, bv;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			bv = bvalid;
			q = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		while (!bv);
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] q);
		logic ta, rv;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = arvalid & arready;
			rv = rvalid;
			d = rdata;
			q = rresp;
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
		end
		while (!rv);
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic ex(input logic [15:0] op);
		wr(`REG_OPCODE, {16'h0, op}, r);
		do
			rd(`REG_STATUS, s, r);
		while (s[7] !== 1'b0);
	endtask

	task automatic setf(input logic [7:0] d);
		wr(`REG_FILE_ADDR, 32'h41, r);
		wr(`REG_FILE_DATA, {24'h0, d}, r);
	endtask

	task automatic t_lit;
		logic [7:0] ops[7], k, e;
		logic [3:0] f;
		ops = '{`OP_LOAD_LITERAL_ACCUM, `OP_ADD_LITERAL_ACCUM, `OP_SUB_ACCUM_FROM_LITERAL, `OP_OR_LITERAL_ACCUM,
			`OP_XOR_LITERAL_ACCUM, `OP_AND_LITERAL_ACCUM, `OP_MULTIPLY_LITERAL_ACCUM};
		for (int i = 0; i < 7; i++)
		begin
			k = (i == 2) ? 8'h88 : 8'h78 + i[7:0];
			wr(`REG_WORK, 32'h88, r);
			wr(`REG_STATUS, 32'h7F, r);
			ex({ops[i], k});
			f = 4'hF;
			case (i)
				0: e = k;
				1: {f, e} = arith(8'h88, k, 1'b0);
				2: {f, e} = arith(k, 8'h77, 1'b1);
				3: e = 8'h88 | k;
				4: e = 8'h88 ^ k;
				5: e = 8'h88 & k;
				default: e = 8'h88;
			endcase
			if (i > 2 && i < 6)
				f[2] = (e == 8'h00);
			`CHK("flags", f, s[3:0]);
			`CHK("cycles", 2'd1, s[9:8]);
			rd(`REG_WORK, v, r);
			`CHK("work", e, v[7:0]);
		end
		rd(`REG_PRODUCT, v, r);
		`CHK("product", 16'h88 * 16'h7E, v[15:0]);
	endtask

	task automatic t_file;
		logic [6:0] ops[3];
		logic [11:0] e;
		ops = '{`OP_XOR_ACCUM_FILE, `OP_ADD_ACCUM_FILE, `OP_ADD_ACCUM_FILE_CARRY};
		for (int j = 0; j < 6; j++)
		begin
			wr(`REG_WORK, 32'h4D, r);
			wr(`REG_STATUS, 32'h71, r);
			setf(8'hC2);
			ex({ops[j % 3], j > 2, 8'h41});
			e = (j % 3 == 0) ? 12'h18F : arith(8'h4D, 8'hC2, j % 3 == 2);
			`CHK("flags", e[11:8], s[3:0]);
			rd(`REG_FILE_DATA, v, r);
			`CHK("file", j > 2 ? e[7:0] : 8'hC2, v[7:0]);
			rd(`REG_WORK, v, r);
			`CHK("work", j > 2 ? 8'h4D : e[7:0], v[7:0]);
		end
		for (int t = 0; t < 2; t++)
		begin
			wr(`REG_WORK, 32'h4D, r);
			setf(8'hC2);
			ex({`OP_CLRF, t[0], 8'h41});
			rd(`REG_WORK, v, r);
			`CHK("work kept", t ? 8'h4D : 8'h00, v[7:0]);
		end
	endtask

	task automatic t_bit;
		logic [4:0] ops[3];
		logic [7:0] m, e;
		ops = '{`OP_BCF, `OP_BSF, `OP_BTG};
		for (int i = 0; i < 24; i++)
		begin
			m = 8'h01 << (i % 8);
			setf(8'hA5);
			ex({ops[i / 8], i[2:0], 8'h41});
			e = i < 8 ? 8'hA5 & ~m : i < 16 ? 8'hA5 | m : 8'hA5 ^ m;
			rd(`REG_FILE_DATA, v, r);
			`CHK("bit op", e, v[7:0]);
			`CHK("bit cycles", 2'd1, s[9:8]);
		end
	endtask

	task automatic t_skip;
		logic sk;
		logic [7:0] fv;
		logic [15:0] p;
		fv = 8'hA5;
		for (int i = 0; i < 24; i++)
		begin
			setf((i >= 16 && i[0]) ? 8'h00 : fv);
			rd(`REG_PC, v, r);
			p = v[15:0];
			case (i / 8)
				0: ex({`OP_BIT_TEST_SKIP_CLEAR, i[2:0], 8'h41});
				1: ex({`OP_BIT_TEST_SKIP_SET, i[2:0], 8'h41});
				default: ex({`OP_TEST_FILE_SKIP_ZERO, 8'h41});
			endcase
			sk = i < 8 ? !fv[i % 8] : i < 16 ? fv[i % 8] : i[0];
			`CHK("skip cycles", sk ? 2'd2 : 2'd1, s[9:8]);
			rd(`REG_PC, v, r);
			`CHK("skip pc", p + (sk ? 16'd2 : 16'd1), v[15:0]);
		end
	endtask

	task automatic t_ctl;
		wr(`REG_PC, 32'h2100, r);
		ex({`OP_CALL, 13'h0123});
		`CHK("call cycles", 2'd2, s[9:8]);
		rd(`REG_PC, v, r);
		`CHK("call pc", 16'h2123, v[15:0]);
		ex(`OP_RETURN);
		rd(`REG_PC, v, r);
		`CHK("return pc", 16'h2101, v[15:0]);
		wr(`REG_PCLATCH, 32'h12, r);
		ex({`OP_LONG_SUBROUTINE_CALL, 8'h34});
		rd(`REG_PC, v, r);
		`CHK("long call pc", 16'h1234, v[15:0]);
		ex({`OP_RETURN_WITH_LITERAL, 8'h5A});
		`CHK("ret cycles", 2'd2, s[9:8]);
		rd(`REG_PC, v, r);
		`CHK("return_with_literal pc", 16'h2102, v[15:0]);
		rd(`REG_WORK, v, r);
		`CHK("return_with_literal work", 8'h5A, v[7:0]);
		ex({`OP_UNCONDITIONAL_BRANCH, 13'h0777});
		rd(`REG_PC, v, r);
		`CHK("unconditional_branch pc", 16'h2777, v[15:0]);
		ex(`OP_INTERRUPT_RETURN);
		`CHK("global_interrupt_disable", 3'b010, {s[6], s[9:8]});
		ex({`OP_TABLE_READ_OP, 2'b00, `PCL_FILE_ADDR});
		`CHK("table cycles", 2'd3, s[9:8]);
	endtask

	task automatic t_misc;
		wr(`REG_BANK, 32'hA5, r);
		ex({`OP_LOAD_BANK_LOW_NIBBLE, 8'hF3});
		rd(`REG_BANK, v, r);
		`CHK("bank low", 8'hA3, v[7:0]);
		ex({`OP_LOAD_BANK_HIGH_NIBBLE, 1'b1, 8'h6F});
		rd(`REG_BANK, v, r);
		`CHK("bank high", 8'h63, v[7:0]);
		wr(`REG_STATUS, 32'h00, r);
		ex(`OP_WATCHDOG_CLEAR);
		`CHK("to pd", 2'b11, s[5:4]);
		ex(`OP_SLEEP);
		`CHK("to pd", 2'b10, s[5:4]);
		`CHK("pulses", 64'h1_0000_0001, {wd_n, sl_n});
		rd(8'h40, v, r);
		`CHK("rd resp", `RESP_SLVERR, r);
		wr(8'h44, 32'h0, r);
		`CHK("wr resp", `RESP_SLVERR, r);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`REG_STATUS, s, r);
		`CHK("reset status", 7'h70, s[6:0]);
		t_lit;
		t_file;
		t_bit;
		t_skip;
		t_ctl;
		t_misc;
		summarize;
	end

	// Generous: under a hundred short bus-driven instructions
	initial
	begin
		repeat (90000) @(posedge aclk);
		mismatches++;
		summarize;
	end
endmodule

bind insn_core insn_core_chk chk_u
(
	.aclk(aclk), .aresetn(aresetn), .awready(awready),
	.wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .arvalid(arvalid), .arready(arready),
	.rdata(rdata), .rvalid(rvalid), .rready(rready),
	.wdt_clear(wdt_clear), .sleep_enter(sleep_enter)
);
